// ### shared/mdafc_map.svh
// Register indices, field positions, reset values and constants of the modem configuration block.
`ifndef MDAFC_MAP_SVH
`define MDAFC_MAP_SVH

`define MDAFC_IDX_TX_DEV       6'h0e
`define MDAFC_IDX_FREQ_CORR    6'h0f
`define MDAFC_IDX_FILTER       6'h10

`define MDAFC_TX_SHAPING_BIT   7
`define MDAFC_TX_EXP_MSB       6
`define MDAFC_TX_EXP_LSB       4
`define MDAFC_TX_MAN_MSB       3
`define MDAFC_TX_MAN_LSB       0
`define MDAFC_SETTLE_MSB       7
`define MDAFC_SETTLE_LSB       6
`define MDAFC_RX_EXP_MSB       5
`define MDAFC_RX_EXP_LSB       4
`define MDAFC_RX_MAN_MSB       3
`define MDAFC_RX_MAN_LSB       0
`define MDAFC_BYPASS_BIT       7
`define MDAFC_SHIFT_MSB        6
`define MDAFC_SHIFT_LSB        5
`define MDAFC_DIV_MSB          4
`define MDAFC_DIV_LSB          0

`define MDAFC_TX_DEV_RST       8'he8
`define MDAFC_FREQ_CORR_RST    8'h9c
`define MDAFC_FILTER_RST       8'h00

`define MDAFC_TX_FRAC_LOW      5'h10
`define MDAFC_TX_FRAC_HIGH     5'h0f
`define MDAFC_RX_FRAC          3'h3
`define MDAFC_RX_THIRD         3'h3
`define MDAFC_CHAN_BW_HZ       19'h4b000

`endif

// ### shared/mdafc_pkg.sv
// Types shared by the modem configuration block.
`default_nettype none
package mdafc_pkg;
    typedef enum logic [1:0] {
        MDAFC_AFC_OFF    = 2'h0,
        MDAFC_AFC_FAST   = 2'h1,
        MDAFC_AFC_MEDIUM = 2'h2,
        MDAFC_AFC_SLOW   = 2'h3
    } mdafc_settling_t;
    typedef enum logic [1:0] {
        MDAFC_RESP_OKAY   = 2'h0,
        MDAFC_RESP_SLVERR = 2'h2
    } mdafc_resp_t;
    typedef logic [7:0] mdafc_reg_t;
endpackage
`default_nettype wire

// ### hdl/mdafc_axil_slave.sv
// AXI4-Lite slave front end that turns bus transfers into single-cycle register accesses.
`timescale 1ns/1ps
`default_nettype none
module mdafc_axil_slave (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst_n,
    // AXI4-Lite write channels
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    // AXI4-Lite read channels
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // Register side
    output logic             wr_fire,
    output logic [7:0]       wr_addr,
    output logic [31:0]      wr_data,
    output logic [3:0]       wr_strb,
    input  wire logic        wr_hit,
    output logic             rd_fire,
    output logic [7:0]       rd_addr,
    input  wire logic [7:0]  rd_data,
    input  wire logic        rd_hit
);
    logic aw_have_q;
    logic w_have_q;
    logic ar_have_q;

    assign awready = !aw_have_q && !bvalid;
    assign wready  = !w_have_q && !bvalid;
    assign arready = !ar_have_q && !rvalid;
    assign wr_fire = aw_have_q && w_have_q && !bvalid;
    assign rd_fire = ar_have_q && !rvalid;

    // Address and data are taken in either order and held until both are present.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            aw_have_q <= 1'b0;
            wr_addr   <= 8'h00;
        end else if (awvalid && awready) begin
            aw_have_q <= 1'b1;
            wr_addr   <= awaddr;
        end else if (wr_fire) begin
            aw_have_q <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            w_have_q <= 1'b0;
            wr_data  <= 32'h0000_0000;
            wr_strb  <= 4'h0;
        end else if (wvalid && wready) begin
            w_have_q <= 1'b1;
            wr_data  <= wdata;
            wr_strb  <= wstrb;
        end else if (wr_fire) begin
            w_have_q <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            bvalid <= 1'b0;
            bresp  <= 2'h0;
        end else if (wr_fire) begin
            bvalid <= 1'b1;
            bresp  <= wr_hit ? mdafc_pkg::MDAFC_RESP_OKAY : mdafc_pkg::MDAFC_RESP_SLVERR;
        end else if (bvalid && bready) begin
            bvalid <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ar_have_q <= 1'b0;
            rd_addr   <= 8'h00;
        end else if (arvalid && arready) begin
            ar_have_q <= 1'b1;
            rd_addr   <= araddr;
        end else if (rd_fire) begin
            ar_have_q <= 1'b0;
        end
    end

    // Unmapped reads return zero with a slave error.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rvalid <= 1'b0;
            rdata  <= 32'h0000_0000;
            rresp  <= 2'h0;
        end else if (rd_fire) begin
            rvalid <= 1'b1;
            rdata  <= {24'h00_0000, rd_hit ? rd_data : 8'h00};
            rresp  <= rd_hit ? mdafc_pkg::MDAFC_RESP_OKAY : mdafc_pkg::MDAFC_RESP_SLVERR;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ### hdl/mdafc_decim_clk.sv
// Decimation clock divider that pulses once every divisor-select plus one clocks.
`timescale 1ns/1ps
`default_nettype none
module mdafc_decim_clk (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       rst_n,
    // Control and output
    input  wire logic [4:0] divisor_select,
    output logic            decim_strobe
);
    logic [4:0] count_q;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            count_q      <= 5'h00;
            decim_strobe <= 1'b0;
        end else if (count_q >= divisor_select) begin
            count_q      <= 5'h00;
            decim_strobe <= 1'b1;
        end else begin
            count_q      <= count_q + 5'h01;
            decim_strobe <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ### hdl/mdafc_config.sv
// Deviation, frequency correction and channel filter configuration registers of the modem.
`timescale 1ns/1ps
`default_nettype none
`include "mdafc_map.svh"
// Operation
// - Shaping bit set means transmitted data gets Gaussian shaping; resets to one.
// - Transmit register holds exponent in bits 6:4 and mantissa in bits 3:0.
// - Lower band deviation is reference times mantissa times two to exponent minus 16.
// - Upper band deviation is reference times mantissa times two to exponent minus 15.
// - Zero transmit mantissa selects on-off keying for receive and transmit.
// - Settling value zero turns frequency correction off with zero average frequency.
// - Settling values 1, 2, 3 average over 1, 2, 4 bit pairs.
// - Correction register holds receive exponent in bits 5:4 and mantissa in 3:0.
// - Expected receive deviation is baud times mantissa times two to exponent minus 3, over 3.
// - Bypass bit set skips the analog image rejection and anti-alias filter.
// - Filter bits 6:5 give extra decimator input shift positions.
// - Filter bits 4:0 select decimation divisor of field plus one.
// - Channel filter bandwidth is 307.2 kHz over the decimation divisor.
module mdafc_config (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst_n,
    // AXI4-Lite write channels
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    // AXI4-Lite read channels
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // Band selection from the synthesiser
    input  wire logic        band_upper,
    // Transmit modulation controls
    output logic             tx_shaping_en_q,
    output logic             ook_mode_q,
    output logic [2:0]       tx_dev_exponent_q,
    output logic [3:0]       tx_dev_mantissa_q,
    output logic [10:0]      tx_dev_scaled_q,
    output logic [4:0]       tx_dev_frac_bits_q,
    // Frequency correction controls
    output logic             afc_enable_q,
    output logic [2:0]       afc_avg_pairs_q,
    output logic [1:0]       rx_dev_exponent_q,
    output logic [3:0]       rx_dev_mantissa_q,
    output logic [6:0]       rx_dev_scaled_q,
    // Channel filter controls
    output logic             filter_bypass_q,
    output logic [1:0]       decimator_input_shift_q,
    output logic [5:0]       decimation_divisor_q,
    output logic [18:0]      filter_bw_hz_q,
    output logic             decim_strobe
);
    logic                       wr_fire;
    logic [7:0]                 wr_addr;
    logic [31:0]                wr_data;
    logic [3:0]                 wr_strb;
    logic                       wr_hit;
    logic                       rd_fire;
    logic [7:0]                 rd_addr;
    logic [7:0]                 rd_data;
    logic                       rd_hit;
    logic                       wr_tx;
    logic                       wr_fc;
    logic                       wr_flt;
    mdafc_pkg::mdafc_reg_t      tx_dev_q;
    mdafc_pkg::mdafc_reg_t      freq_corr_q;
    mdafc_pkg::mdafc_reg_t      filter_q;
    mdafc_pkg::mdafc_settling_t settling;
    logic [4:0]                 div_sel;

    mdafc_axil_slave u_slave (
        .clock   (clock),
        .rst_n   (rst_n),
        .awaddr  (awaddr),
        .awvalid (awvalid),
        .awready (awready),
        .wdata   (wdata),
        .wstrb   (wstrb),
        .wvalid  (wvalid),
        .wready  (wready),
        .bresp   (bresp),
        .bvalid  (bvalid),
        .bready  (bready),
        .araddr  (araddr),
        .arvalid (arvalid),
        .arready (arready),
        .rdata   (rdata),
        .rresp   (rresp),
        .rvalid  (rvalid),
        .rready  (rready),
        .wr_fire (wr_fire),
        .wr_addr (wr_addr),
        .wr_data (wr_data),
        .wr_strb (wr_strb),
        .wr_hit  (wr_hit),
        .rd_fire (rd_fire),
        .rd_addr (rd_addr),
        .rd_data (rd_data),
        .rd_hit  (rd_hit)
    );

    // Address decode: one aligned word per register, index times four.
    assign wr_tx  = (wr_addr[1:0] == 2'h0) && (wr_addr[7:2] == `MDAFC_IDX_TX_DEV);
    assign wr_fc  = (wr_addr[1:0] == 2'h0) && (wr_addr[7:2] == `MDAFC_IDX_FREQ_CORR);
    assign wr_flt = (wr_addr[1:0] == 2'h0) && (wr_addr[7:2] == `MDAFC_IDX_FILTER);
    assign wr_hit = wr_tx || wr_fc || wr_flt;

    // Register storage; only byte lane zero carries data.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tx_dev_q <= `MDAFC_TX_DEV_RST;
        end else if (wr_fire && wr_tx && wr_strb[0]) begin
            tx_dev_q <= wr_data[7:0];
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            freq_corr_q <= `MDAFC_FREQ_CORR_RST;
        end else if (wr_fire && wr_fc && wr_strb[0]) begin
            freq_corr_q <= wr_data[7:0];
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            filter_q <= `MDAFC_FILTER_RST;
        end else if (wr_fire && wr_flt && wr_strb[0]) begin
            filter_q <= wr_data[7:0];
        end
    end

    // Read multiplexer.
    always_comb begin
        rd_data = 8'h00;
        rd_hit  = 1'b0;
        if (rd_addr[1:0] == 2'h0) begin
            if (rd_addr[7:2] == `MDAFC_IDX_TX_DEV) begin
                rd_data = tx_dev_q;
                rd_hit  = 1'b1;
            end else if (rd_addr[7:2] == `MDAFC_IDX_FREQ_CORR) begin
                rd_data = freq_corr_q;
                rd_hit  = 1'b1;
            end else if (rd_addr[7:2] == `MDAFC_IDX_FILTER) begin
                rd_data = filter_q;
                rd_hit  = 1'b1;
            end
        end
    end

    // Transmit deviation controls.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tx_shaping_en_q    <= 1'b0;
            ook_mode_q         <= 1'b0;
            tx_dev_exponent_q  <= 3'h0;
            tx_dev_mantissa_q  <= 4'h0;
            tx_dev_scaled_q    <= 11'h000;
            tx_dev_frac_bits_q <= 5'h00;
        end else begin
            tx_shaping_en_q    <= tx_dev_q[`MDAFC_TX_SHAPING_BIT];
            tx_dev_exponent_q  <= tx_dev_q[`MDAFC_TX_EXP_MSB:`MDAFC_TX_EXP_LSB];
            tx_dev_mantissa_q  <= tx_dev_q[`MDAFC_TX_MAN_MSB:`MDAFC_TX_MAN_LSB];
            ook_mode_q         <= tx_dev_q[`MDAFC_TX_MAN_MSB:`MDAFC_TX_MAN_LSB] == 4'h0;
            tx_dev_scaled_q    <= {7'h00, tx_dev_q[`MDAFC_TX_MAN_MSB:`MDAFC_TX_MAN_LSB]}
                                  << tx_dev_q[`MDAFC_TX_EXP_MSB:`MDAFC_TX_EXP_LSB];
            tx_dev_frac_bits_q <= band_upper ? `MDAFC_TX_FRAC_HIGH : `MDAFC_TX_FRAC_LOW;
        end
    end

    // Frequency correction controls.
    assign settling = mdafc_pkg::mdafc_settling_t'(freq_corr_q[`MDAFC_SETTLE_MSB:`MDAFC_SETTLE_LSB]);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            afc_enable_q    <= 1'b0;
            afc_avg_pairs_q <= 3'h0;
        end else begin
            unique case (settling)
                mdafc_pkg::MDAFC_AFC_OFF: begin
                    afc_enable_q    <= 1'b0;
                    afc_avg_pairs_q <= 3'h0;
                end
                mdafc_pkg::MDAFC_AFC_FAST: begin
                    afc_enable_q    <= 1'b1;
                    afc_avg_pairs_q <= 3'h1;
                end
                mdafc_pkg::MDAFC_AFC_MEDIUM: begin
                    afc_enable_q    <= 1'b1;
                    afc_avg_pairs_q <= 3'h2;
                end
                mdafc_pkg::MDAFC_AFC_SLOW: begin
                    afc_enable_q    <= 1'b1;
                    afc_avg_pairs_q <= 3'h4;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rx_dev_exponent_q <= 2'h0;
            rx_dev_mantissa_q <= 4'h0;
            rx_dev_scaled_q   <= 7'h00;
        end else begin
            rx_dev_exponent_q <= freq_corr_q[`MDAFC_RX_EXP_MSB:`MDAFC_RX_EXP_LSB];
            rx_dev_mantissa_q <= freq_corr_q[`MDAFC_RX_MAN_MSB:`MDAFC_RX_MAN_LSB];
            rx_dev_scaled_q   <= {3'h0, freq_corr_q[`MDAFC_RX_MAN_MSB:`MDAFC_RX_MAN_LSB]}
                                 << freq_corr_q[`MDAFC_RX_EXP_MSB:`MDAFC_RX_EXP_LSB];
        end
    end

    // Channel filter controls.
    assign div_sel = filter_q[`MDAFC_DIV_MSB:`MDAFC_DIV_LSB];

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            filter_bypass_q         <= 1'b0;
            decimator_input_shift_q <= 2'h0;
            decimation_divisor_q    <= 6'h01;
            filter_bw_hz_q          <= `MDAFC_CHAN_BW_HZ;
        end else begin
            filter_bypass_q         <= filter_q[`MDAFC_BYPASS_BIT];
            decimator_input_shift_q <= filter_q[`MDAFC_SHIFT_MSB:`MDAFC_SHIFT_LSB];
            decimation_divisor_q    <= {1'b0, div_sel} + 6'h01;
            filter_bw_hz_q          <= `MDAFC_CHAN_BW_HZ / ({14'h0000, div_sel} + 19'h00001);
        end
    end

    mdafc_decim_clk u_decim (
        .clock          (clock),
        .rst_n          (rst_n),
        .divisor_select (div_sel),
        .decim_strobe   (decim_strobe)
    );

    // Checks.
    AST_TX_WRITE: assert property (@(posedge clock) disable iff (!rst_n)
        (wr_fire && wr_tx && wr_strb[0]) |=> (tx_dev_q == $past(wr_data[7:0])))
        else $error("transmit deviation register missed a write");

    AST_HOLD: assert property (@(posedge clock) disable iff (!rst_n)
        !(wr_fire && wr_fc) |=> $stable(freq_corr_q))
        else $error("frequency correction register changed without a write");

    AST_SHAPING: assert property (@(posedge clock) disable iff (!rst_n)
        (wr_fire && wr_tx && wr_strb[0]) |-> ##2 (tx_shaping_en_q == $past(wr_data[7], 2)))
        else $error("shaping enable does not follow the written bit");

    AST_OOK: assert property (@(posedge clock) disable iff (!rst_n)
        ##1 (ook_mode_q == ($past(tx_dev_q[3:0]) == 4'h0)))
        else $error("on-off keying mode disagrees with the mantissa");

    AST_TX_SCALE: assert property (@(posedge clock) disable iff (!rst_n)
        ##1 (tx_dev_scaled_q == 11'(tx_dev_mantissa_q) << tx_dev_exponent_q))
        else $error("transmit deviation scale is wrong");

    AST_BAND: assert property (@(posedge clock) disable iff (!rst_n)
        $past(band_upper) |-> (tx_dev_frac_bits_q == 5'h0f))
        else $error("upper band fraction is not fifteen bits");

    AST_AFC_OFF: assert property (@(posedge clock) disable iff (!rst_n)
        (settling == mdafc_pkg::MDAFC_AFC_OFF) [*2] |-> !afc_enable_q && (afc_avg_pairs_q == 3'h0))
        else $error("frequency correction active while settling is off");

    AST_AFC_SLOW: assert property (@(posedge clock) disable iff (!rst_n)
        (settling == mdafc_pkg::MDAFC_AFC_SLOW) |=> (afc_avg_pairs_q == 3'h4))
        else $error("slowest settling does not average four pairs");

    AST_RX_SCALE: assert property (@(posedge clock) disable iff (!rst_n)
        ##1 (rx_dev_scaled_q == 7'(rx_dev_mantissa_q) << rx_dev_exponent_q))
        else $error("receive deviation scale is wrong");

    AST_BYPASS: assert property (@(posedge clock) disable iff (!rst_n)
        (wr_fire && wr_flt && wr_strb[0]) |-> ##2 (filter_bypass_q == $past(wr_data[7], 2)))
        else $error("filter bypass does not follow the written bit");

    AST_DIVISOR: assert property (@(posedge clock) disable iff (!rst_n)
        ##1 (decimation_divisor_q == 6'($past(div_sel)) + 6'h01))
        else $error("decimation divisor is not field plus one");

    AST_STROBE: assert property (@(posedge clock) disable iff (!rst_n)
        ($rose(decim_strobe) && $stable(div_sel) && (div_sel == 5'h01))
        |=> !decim_strobe ##1 (decim_strobe || ($past(div_sel) != 5'h01)))
        else $error("decimation strobe period wrong for divisor two");

    AST_BW: assert property (@(posedge clock) disable iff (!rst_n)
        ($past(div_sel) == 5'h1f) |-> (filter_bw_hz_q == 19'd9600))
        else $error("bandwidth for divisor thirty-two is not 9600 Hz");

    AST_SHIFT: assert property (@(posedge clock) disable iff (!rst_n)
        (wr_fire && wr_flt && wr_strb[0]) |-> ##2 (decimator_input_shift_q == $past(wr_data[6:5], 2)))
        else $error("decimator input shift does not follow the written field");

    AST_RX_FIELDS: assert property (@(posedge clock) disable iff (!rst_n)
        (wr_fire && wr_fc && wr_strb[0]) |-> ##2 (rx_dev_mantissa_q == $past(wr_data[3:0], 2)))
        else $error("receive mantissa does not follow the written field");
endmodule
`default_nettype wire

// ### bench/mdafc_config_tb.sv
// Self-checking testbench of the modem configuration register block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin errors++; \
    $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module modem_deviation_afc_filter_config_tb;
    logic        clock = 1'b0, rst_n = 1'b0, band_upper = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0]  wstrb = 4'h0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    logic        shp, ook, afc, byp, strobe;
    logic [2:0]  txe, pairs;
    logic [3:0]  txm, rxm;
    logic [10:0] txs;
    logic [4:0]  frac;
    logic [1:0]  rxe, shf;
    logic [6:0]  rxs;
    logic [5:0]  dvs;
    logic [18:0] bw;
    int          errors = 0, checks_done = 0;
    mdafc_pkg::mdafc_reg_t mirror [3];
    logic [7:0]  addrs [3] = '{8'h38, 8'h3c, 8'h40};
    logic [1:0]  resp;
    logic [31:0] rv;
    int          idx;
    logic [7:0]  val;
    mdafc_config dut (.clock(clock), .rst_n(rst_n), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .band_upper(band_upper), .tx_shaping_en_q(shp), .ook_mode_q(ook),
        .tx_dev_exponent_q(txe), .tx_dev_mantissa_q(txm), .tx_dev_scaled_q(txs), .tx_dev_frac_bits_q(frac),
        .afc_enable_q(afc), .afc_avg_pairs_q(pairs), .rx_dev_exponent_q(rxe), .rx_dev_mantissa_q(rxm),
        .rx_dev_scaled_q(rxs), .filter_bypass_q(byp), .decimator_input_shift_q(shf),
        .decimation_divisor_q(dvs), .filter_bw_hz_q(bw), .decim_strobe(strobe));
    always #10 clock = ~clock;
    task automatic end_sim();
        $display("errors %0d, checks %0d", errors, checks_done);
        if (errors == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic bound(input int n);
        if (n > 60) begin
            errors++;
            end_sim();
        end
    endtask
    function automatic logic [2:0] exp_pairs(input logic [1:0] s);
        return (s == 2'h3) ? 3'h4 : {1'b0, s};
    endfunction
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s, output logic [1:0] r);
        logic ad, wd, ar, wrd, b;
        logic [31:0] r32;
        int n;
        @(posedge clock);
        ad = 1'b0; wd = 1'b0; n = 0; r32 = $urandom;
        awaddr <= a; awvalid <= 1'b1; wdata <= {r32[23:0], d}; wstrb <= s; wvalid <= 1'b1;
        while (!(ad && wd)) begin
            @(negedge clock); ar = awready; wrd = wready;
            @(posedge clock);
            if (!ad && ar) begin ad = 1'b1; awvalid <= 1'b0; end
            if (!wd && wrd) begin wd = 1'b1; wvalid <= 1'b0; end
            n++; bound(n);
        end
        bready <= 1'b1; n = 0;
        do begin
            @(negedge clock); b = bvalid; r = bresp;
            @(posedge clock); n++; bound(n);
        end while (!b);
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ar, v;
        int n;
        @(posedge clock);
        n = 0; araddr <= a; arvalid <= 1'b1;
        do begin
            @(negedge clock); ar = arready;
            @(posedge clock); n++; bound(n);
        end while (!ar);
        arvalid <= 1'b0; rready <= 1'b1; n = 0;
        do begin
            @(negedge clock); v = rvalid; d = rdata; r = rresp;
            @(posedge clock); n++; bound(n);
        end while (!v);
        rready <= 1'b0;
    endtask
    task automatic check_all();
        mdafc_pkg::mdafc_reg_t t, f, g;
        int n;
        @(negedge clock);
        t = mirror[0]; f = mirror[1]; g = mirror[2];
        `CHK(shp, t[7])
        `CHK({txe, txm}, t[6:0])
        `CHK(txs, {7'h0, t[3:0]} << t[6:4])
        `CHK(frac, band_upper ? 5'h0f : 5'h10)
        `CHK(ook, t[3:0] == 4'h0)
        `CHK(afc, f[7:6] != 2'h0)
        `CHK(pairs, exp_pairs(f[7:6]))
        `CHK({rxe, rxm}, f[5:0])
        `CHK(rxs, {3'h0, f[3:0]} << f[5:4])
        `CHK(byp, g[7])
        `CHK(shf, g[6:5])
        `CHK(dvs, {1'b0, g[4:0]} + 6'h01)
        `CHK(bw, 19'(32'd307200 / ({27'h0, g[4:0]} + 32'd1)))
        for (int i = 0; i < 3; i++) begin
            rd(addrs[i], rv, resp);
            `CHK(rv, {24'h0, mirror[i]})
            `CHK(resp, mdafc_pkg::MDAFC_RESP_OKAY)
        end
        n = 0;
        while (!strobe) begin @(negedge clock); n++; bound(n); end
        n = 0;
        do begin @(negedge clock); n++; bound(n); end while (!strobe);
        `CHK(n, {26'h0, g[4:0]} + 1)
    endtask
    task automatic put(input int i, input logic [7:0] d);
        wr(addrs[i], d, 4'h1, resp);
        `CHK(resp, mdafc_pkg::MDAFC_RESP_OKAY)
        mirror[i] = d;
        check_all();
    endtask
    initial begin
        void'($urandom(46952));
        mirror = '{8'he8, 8'h9c, 8'h00};
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        check_all();
        put(0, 8'h00); put(1, 8'h00); put(2, 8'h1f); put(0, 8'hff); put(1, 8'hff); put(2, 8'hff);
        put(1, 8'h40); put(1, 8'h80); put(2, 8'h00);
        put(0, 8'hcb); put(1, 8'hdb); put(2, 8'h01);
        wr(8'h38, 8'h55, 4'he, resp);
        `CHK(resp, mdafc_pkg::MDAFC_RESP_OKAY)
        foreach (addrs[k]) begin
            wr(addrs[k] + 8'h0c - 8'h08 * k[7:0] + 8'h01, 8'h5a, 4'hf, resp);
            `CHK(resp, mdafc_pkg::MDAFC_RESP_SLVERR)
        end
        wr(8'h44, 8'h5a, 4'hf, resp);
        `CHK(resp, mdafc_pkg::MDAFC_RESP_SLVERR)
        rd(8'h39, rv, resp);
        `CHK(resp, mdafc_pkg::MDAFC_RESP_SLVERR)
        `CHK(rv, 32'h0)
        check_all();
        for (int it = 0; it < 40; it++) begin
            idx = $urandom % 3;
            val = 8'($urandom);
            @(posedge clock);
            band_upper <= 1'($urandom);
            put(idx, val);
        end
        end_sim();
    end
endmodule
`undef CHK
`default_nettype wire
